//--- logic/smcf_map.svh
// opcodes, field positions and bit and byte counts of the serial memory command front end
`ifndef SMCF_MAP_SVH
`define SMCF_MAP_SVH
`define SMCF_OP_SET_LATCH    8'h06
`define SMCF_OP_CLR_LATCH    8'h04
`define SMCF_OP_STATUS_RD    8'h05
`define SMCF_OP_STATUS_WR    8'h01
`define SMCF_OP_MEM_WR       8'h02
`define SMCF_OP_MEM_RD       8'h03
`define SMCF_OP_FAST_RD      8'h0B
`define SMCF_OP_SS_WR        8'h42
`define SMCF_OP_SS_RD        8'h4B
`define SMCF_OP_DEV_ID       8'h9F
`define SMCF_OP_UNIQUE_ID    8'h4C
`define SMCF_OP_SN_WR        8'hC2
`define SMCF_OP_SN_RD        8'hC3
`define SMCF_OP_DEEP_PD      8'hBA
`define SMCF_OP_HIBERNATE    8'hB9
`define SMCF_LATCH_BIT       1
`define SMCF_ADDR_BYTES      2'h3
`define SMCF_BIT_LAST        3'h7
`define SMCF_BIT_FIRST       3'h0
`endif

//--- logic/smcf_pkg.sv
// types of the serial memory command front end
package smcf_pkg;
  typedef enum logic [3:0] {
    SMCF_CMD_NONE       = 4'h0,
    SMCF_CMD_SET_LATCH  = 4'h1,
    SMCF_CMD_CLR_LATCH  = 4'h2,
    SMCF_CMD_STATUS_RD  = 4'h3,
    SMCF_CMD_STATUS_WR  = 4'h4,
    SMCF_CMD_MEM_WR     = 4'h5,
    SMCF_CMD_MEM_RD     = 4'h6,
    SMCF_CMD_FAST_RD    = 4'h7,
    SMCF_CMD_SS_WR      = 4'h8,
    SMCF_CMD_SS_RD      = 4'h9,
    SMCF_CMD_DEV_ID     = 4'hA,
    SMCF_CMD_UNIQUE_ID  = 4'hB,
    SMCF_CMD_SN_WR      = 4'hC,
    SMCF_CMD_SN_RD      = 4'hD,
    SMCF_CMD_DEEP_PD    = 4'hE,
    SMCF_CMD_HIBERNATE  = 4'hF
  } smcf_cmd_t;

  // frame phases, gray along opcode -> address -> data
  typedef enum logic [1:0] {
    SMCF_ST_IDLE   = 2'b00,
    SMCF_ST_OPCODE = 2'b01,
    SMCF_ST_ADDR   = 2'b11,
    SMCF_ST_DATA   = 2'b10
  } smcf_state_t;
endpackage

//--- logic/smcf_pin_if.sv
// synchronised pin levels and edge events between the sampler and the decoder
`timescale 1ns/1ps
interface smcf_pin_if;
  logic sel;
  logic sel_fall;
  logic sel_rise;
  logic sck_lvl;
  logic sck_rise;
  logic sck_fall;
  logic sdi;
  modport src (output sel, sel_fall, sel_rise, sck_lvl, sck_rise, sck_fall, sdi);
  modport dst (input  sel, sel_fall, sel_rise, sck_lvl, sck_rise, sck_fall, sdi);
endinterface

//--- logic/smcf_pin_sync.sv
// two-stage synchronisers and edge detection for the serial pins
`timescale 1ns/1ps
module smcf_pin_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // raw pins
  input  wire logic sel_n_pin,
  input  wire logic sck_pin,
  input  wire logic sdi_pin,
  // synchronised view
  smcf_pin_if.src   pins
);
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
  } smcf_sync_t;

  smcf_sync_t q, d;

  // s1 feeds s2 only; s3 is the previous s2 value for edge finding
  always_comb begin
    d    = q;
    d.s1 = {~sel_n_pin, sck_pin, sdi_pin};
    d.s2 = q.s1;
    d.s3 = q.s2;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pins.sel      = q.s2[2];
  assign pins.sel_fall = q.s2[2] & ~q.s3[2];
  assign pins.sel_rise = ~q.s2[2] & q.s3[2];
  assign pins.sck_lvl  = q.s2[1];
  assign pins.sck_rise = q.s2[1] & ~q.s3[1];
  assign pins.sck_fall = ~q.s2[1] & q.s3[1];
  assign pins.sdi      = q.s2[0];
endmodule

//--- logic/smcf_frontend.sv
// serial command front end: opcode and address shifter, decoder and write latch
`timescale 1ns/1ps
`include "smcf_map.svh"

module smcf_frontend
  import smcf_pkg::*;
#(
  parameter int ADDR_W = 20
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // serial pins
  input  wire logic              sel_n_pin,
  input  wire logic              sck_pin,
  input  wire logic              sdi_pin,
  output logic                   sdo_o,
  output logic                   sdo_oe_n,
  // downstream command port
  output smcf_pkg::smcf_cmd_t    cmd_o,
  output logic                   cmd_valid_o,
  output logic [ADDR_W-1:0]      addr_o,
  output logic                   addr_valid_o,
  output logic [7:0]             rx_byte_o,
  output logic                   rx_byte_valid_o,
  output logic                   write_allowed_o,
  output logic                   write_latch_flag,
  output logic                   mode3_o,
  output logic                   frame_end_o,
  // read data from downstream, loaded at the opcode, last address byte and each data byte boundary
  input  wire logic [7:0]        tx_byte_i,
  input  wire logic [7:0]        status_i
);
  import smcf_pkg::*;

  // synchronised pin view shared with the sampler
  smcf_pin_if pins ();

  // every pin passes two flip-flops first; costs two clocks of latency per edge
  smcf_pin_sync u_sync (
    .clk       (clk),
    .rst       (rst),
    .sel_n_pin (sel_n_pin),
    .sck_pin   (sck_pin),
    .sdi_pin   (sdi_pin),
    .pins      (pins)
  );

  // whole front end state: one register, one next-value copy
  typedef struct packed {
    smcf_state_t         st;
    smcf_cmd_t           cmd;
    logic                mode3;
    logic                armed;
    logic [2:0]          bit_cnt;
    logic [1:0]          addr_cnt;
    logic [7:0]          shift;
    logic [23:0]         addr_sh;
    logic [7:0]          tx_sh;
    logic                latch;
    logic                oe_n;                 // active low, so the pin leaves a flop directly
    logic                sdo;
    logic                cmd_valid;
    logic [ADDR_W-1:0]   addr;
    logic                addr_valid;
    logic [7:0]          rx_byte;
    logic                rx_valid;
    logic                frame_end;
  } smcf_fe_t;

  // q is the register, d its next value
  smcf_fe_t q, d;

  // opcode decode; every value off the table maps to no command
  function automatic smcf_cmd_t decode_op(input logic [7:0] op);
    unique case (op)
      `SMCF_OP_SET_LATCH: decode_op = SMCF_CMD_SET_LATCH;
      `SMCF_OP_CLR_LATCH: decode_op = SMCF_CMD_CLR_LATCH;
      `SMCF_OP_STATUS_RD: decode_op = SMCF_CMD_STATUS_RD;
      `SMCF_OP_STATUS_WR: decode_op = SMCF_CMD_STATUS_WR;
      `SMCF_OP_MEM_WR:    decode_op = SMCF_CMD_MEM_WR;
      `SMCF_OP_MEM_RD:    decode_op = SMCF_CMD_MEM_RD;
      `SMCF_OP_FAST_RD:   decode_op = SMCF_CMD_FAST_RD;
      `SMCF_OP_SS_WR:     decode_op = SMCF_CMD_SS_WR;
      `SMCF_OP_SS_RD:     decode_op = SMCF_CMD_SS_RD;
      `SMCF_OP_DEV_ID:    decode_op = SMCF_CMD_DEV_ID;
      `SMCF_OP_UNIQUE_ID: decode_op = SMCF_CMD_UNIQUE_ID;
      `SMCF_OP_SN_WR:     decode_op = SMCF_CMD_SN_WR;
      `SMCF_OP_SN_RD:     decode_op = SMCF_CMD_SN_RD;
      `SMCF_OP_DEEP_PD:   decode_op = SMCF_CMD_DEEP_PD;
      `SMCF_OP_HIBERNATE: decode_op = SMCF_CMD_HIBERNATE;
      default:            decode_op = SMCF_CMD_NONE;
    endcase
  endfunction

  // commands followed by three address bytes
  function automatic logic has_addr(input smcf_cmd_t c);
    has_addr = (c == SMCF_CMD_MEM_WR) || (c == SMCF_CMD_MEM_RD) ||
               (c == SMCF_CMD_FAST_RD) || (c == SMCF_CMD_SS_WR) ||
               (c == SMCF_CMD_SS_RD);
  endfunction

  // commands gated by the latch and cleared when the frame ends
  function automatic logic is_write(input smcf_cmd_t c);
    is_write = (c == SMCF_CMD_STATUS_WR) || (c == SMCF_CMD_MEM_WR) ||
               (c == SMCF_CMD_SS_WR) || (c == SMCF_CMD_SN_WR);
  endfunction

  // commands that drive the output during their data phase
  function automatic logic is_read(input smcf_cmd_t c);
    is_read = (c == SMCF_CMD_STATUS_RD) || (c == SMCF_CMD_MEM_RD) ||
              (c == SMCF_CMD_FAST_RD) || (c == SMCF_CMD_SS_RD) ||
              (c == SMCF_CMD_DEV_ID) || (c == SMCF_CMD_UNIQUE_ID) ||
              (c == SMCF_CMD_SN_RD);
  endfunction

  // per-cycle helpers of the next-state logic
  logic [7:0] byte_in;
  logic       rise_ok;
  logic [7:0] status_view;
  smcf_cmd_t  op_cmd;

  // status byte with the latch flag forced in; a status write cannot touch it
  // other bits pass through untouched; downstream owns their layout
  always_comb begin
    status_view                 = status_i;
    status_view[`SMCF_LATCH_BIT] = q.latch;
  end

  // in mode 3 the idle-high level is not an edge; armed after the first fall
  assign rise_ok = pins.sck_rise && (q.armed || !q.mode3);
  assign byte_in = {q.shift[6:0], pins.sdi};

  // decoded once per cycle; only used at the opcode boundary
  always_comb begin
    op_cmd = decode_op(byte_in);
  end

  // next state: select edges win over clock edges, so a cut frame still closes
  // and the latch rule still applies to it
  always_comb begin
    d            = q;
    d.cmd_valid  = 1'b0;
    d.addr_valid = 1'b0;
    d.rx_valid   = 1'b0;
    d.frame_end  = 1'b0;

    if (pins.sel_fall) begin
      // new frame: opcode phase, mode from the clock level now
      d.st       = SMCF_ST_OPCODE;
      d.mode3    = pins.sck_lvl;
      d.armed    = 1'b0;
      d.bit_cnt  = `SMCF_BIT_FIRST;
      d.addr_cnt = 2'h0;
      d.cmd      = SMCF_CMD_NONE;
      d.oe_n     = 1'b1;
      d.tx_sh    = 8'h00;                                   // no stale read bits cross frames
    end else if (pins.sel_rise || !pins.sel) begin
      // deselected: input ignored, output released
      d.st    = SMCF_ST_IDLE;
      d.oe_n  = 1'b1;
      if (pins.sel_rise) begin
        d.frame_end = 1'b1;
        // clear on the rising select after a write or clear command
        // a write cut short still counts, so a half-sent write needs a new set
        if (is_write(q.cmd) || q.cmd == SMCF_CMD_CLR_LATCH) begin
          d.latch = 1'b0;
        end
      end
    end else begin
      // a fall proves the clock has toggled, so mode 3 may count rises from here
      if (pins.sck_fall) begin
        d.armed = 1'b1;
      end
      // shift on each accepted rise; idle after a bad opcode shifts nothing
      if (rise_ok && q.st != SMCF_ST_IDLE) begin
        d.shift   = byte_in;
        d.bit_cnt = q.bit_cnt + 3'h1;
        if (q.st == SMCF_ST_ADDR) begin
          d.addr_sh = {q.addr_sh[22:0], pins.sdi};
        end
      end

      // byte boundary on the eighth rising edge
      if (rise_ok && q.bit_cnt == `SMCF_BIT_LAST) begin
        unique case (q.st)
          SMCF_ST_OPCODE: begin
            d.cmd       = op_cmd;
            d.cmd_valid = op_cmd != SMCF_CMD_NONE;
            if (op_cmd == SMCF_CMD_NONE) begin
              d.st = SMCF_ST_IDLE;
            end else if (has_addr(op_cmd)) begin
              d.st = SMCF_ST_ADDR;
            end else begin
              d.st = SMCF_ST_DATA;
            end
            if (op_cmd == SMCF_CMD_SET_LATCH) begin
              d.latch = 1'b1;
            end
            // reads without an address answer from the first data fall on
            if (op_cmd == SMCF_CMD_STATUS_RD) begin
              d.tx_sh = status_view;
            end else begin
              d.tx_sh = tx_byte_i;
            end
          end
          SMCF_ST_ADDR: begin
            d.addr_cnt = q.addr_cnt + 2'h1;
            if (q.addr_cnt == `SMCF_ADDR_BYTES - 2'h1) begin
              // leading four bits discarded by taking the low part only
              d.addr       = d.addr_sh[ADDR_W-1:0];
              d.addr_valid = 1'b1;
              d.st         = SMCF_ST_DATA;
              // tx_byte_i is taken here, before addr_valid_o is out: downstream
              // must have it ready; the fast-read dummy byte is not modelled
              d.tx_sh      = tx_byte_i;
            end
          end
          SMCF_ST_DATA: begin
            // every data byte goes downstream; a read also reloads its next byte
            d.rx_byte  = byte_in;
            d.rx_valid = 1'b1;
            d.tx_sh    = (q.cmd == SMCF_CMD_STATUS_RD) ? status_view : tx_byte_i;
          end
          default: begin
            d.st = SMCF_ST_IDLE;
          end
        endcase
      end else if (q.st == SMCF_ST_ADDR && q.addr_cnt == 2'h0 && q.bit_cnt == 3'h0) begin
        // hold until first address bit; nothing to do
        d.st = q.st;
      end

      // output shifts on falling edges while a read sits in its data phase
      if (pins.sck_fall && q.st == SMCF_ST_DATA && is_read(q.cmd)) begin
        d.oe_n  = 1'b0;
        d.sdo   = q.tx_sh[7];
        d.tx_sh = {q.tx_sh[6:0], 1'b0};
      end
    end
  end

  // tx_sh loads at a byte boundary, so the first falling edge after it emits bit 7
  always_ff @(posedge clk) begin
    if (rst) begin
      q       <= '0;
      q.st    <= SMCF_ST_IDLE;
      q.cmd   <= SMCF_CMD_NONE;
      q.latch <= 1'b0;
      q.oe_n  <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // all outputs straight from flip-flops; sdo keeps its last bit, the enable decides
  assign sdo_o            = q.sdo;
  assign sdo_oe_n         = q.oe_n;

  // downstream command port
  assign cmd_o            = q.cmd;
  assign cmd_valid_o      = q.cmd_valid;
  assign addr_o           = q.addr;
  assign addr_valid_o     = q.addr_valid;
  assign rx_byte_o        = q.rx_byte;
  assign rx_byte_valid_o  = q.rx_valid;

  // latch state, shared by the write gate and the status flag
  assign write_allowed_o  = q.latch;
  assign write_latch_flag = q.latch;
  assign mode3_o          = q.mode3;
  assign frame_end_o      = q.frame_end;
endmodule

//--- tb/smcf_frontend_assertions.sv
// concurrent checks on the front end's top ports
`timescale 1ns/1ps
module smcf_frontend_assertions
  import smcf_pkg::*;
#(
  parameter int ADDR_W = 20
) (
  // clock and reset
  input wire logic              clk,
  input wire logic              rst,
  // serial pins
  input wire logic              sel_n_pin,
  input wire logic              sck_pin,
  input wire logic              sdi_pin,
  input wire logic              sdo_o,
  input wire logic              sdo_oe_n,
  // downstream side
  input wire smcf_pkg::smcf_cmd_t cmd_o,
  input wire logic              cmd_valid_o,
  input wire logic [ADDR_W-1:0] addr_o,
  input wire logic              addr_valid_o,
  input wire logic [7:0]        rx_byte_o,
  input wire logic              rx_byte_valid_o,
  input wire logic              write_allowed_o,
  input wire logic              write_latch_flag,
  input wire logic              mode3_o,
  input wire logic              frame_end_o,
  input wire logic [7:0]        tx_byte_i,
  input wire logic [7:0]        status_i
);
  logic [1:0] fe_hist_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // remembers a frame end that lands just before the latch drops
  always_ff @(posedge clk) begin
    fe_hist_q <= {fe_hist_q[0], frame_end_o};
  end
  sequence s_sel_fall;
    $fell(sel_n_pin);
  endsequence
  // pin levels need a few cycles through the synchronisers
  sequence s_mode_seen;
    ##6 (mode3_o == $past(sck_pin, 6));
  endsequence
  a_mode_pick: assert property (s_sel_fall |-> s_mode_seen)
    else $error("mode does not follow clock level at select");
  a_desel_quiet: assert property (sel_n_pin [*8] |-> sdo_oe_n)
    else $error("output driven while deselected");
  a_oe_reads: assert property (!sdo_oe_n |-> cmd_o inside {SMCF_CMD_STATUS_RD, SMCF_CMD_MEM_RD,
    SMCF_CMD_FAST_RD, SMCF_CMD_SS_RD, SMCF_CMD_DEV_ID, SMCF_CMD_UNIQUE_ID, SMCF_CMD_SN_RD})
    else $error("output driven for a command that returns nothing");
  a_sdo_on_fall: assert property (!sdo_oe_n && !sel_n_pin && $changed(sdo_o) |-> !sck_pin)
    else $error("output changed away from a falling clock");
  a_cmd_single: assert property (cmd_valid_o |=> !cmd_valid_o [*8])
    else $error("command strobe repeated");
  a_latch_agree: assert property (cmd_valid_o && cmd_o == SMCF_CMD_SET_LATCH |->
    write_allowed_o && write_latch_flag)
    else $error("write gate differs from latch flag");
  a_latch_set: assert property ($rose(write_latch_flag) |-> ##[0:2] (cmd_o == SMCF_CMD_SET_LATCH))
    else $error("latch set without the set command");
  a_latch_clear: assert property ($fell(write_latch_flag) |-> ##[0:2] (frame_end_o || |fe_hist_q))
    else $error("latch cleared away from select rise");
  a_frame_end_sel: assert property (frame_end_o |-> sel_n_pin && $past(sel_n_pin, 2))
    else $error("frame end without select high");
endmodule

//--- tb/smcf_master.sv
// serial bus master model that drives the front end's pins
`timescale 1ns/1ps
module smcf_master (
  // placement clock
  input  wire logic clk,
  // serial lines
  output logic      sel_n,
  output logic      sck,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe_n
);
  logic mode3_q;
  initial begin
    sel_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
    mode3_q = 1'b0;
  end
  // half of the 160 ns link period, placed just after a clock edge
  task automatic half();
    repeat (20) @(posedge clk);
    #1;
  endtask
  // clock idles at the mode's level before select falls
  task automatic start(input logic m3);
    mode3_q = m3;
    sck = m3;
    half();
    sel_n = 1'b0;
    half();
  endtask
  // msb first; reply sampled on each rise, unknown when released
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      sdi = tx[i];
      half();
      sck = 1'b1;
      rx[i] = sdo_oe_n ? 1'bx : sdo;
      half();
    end
  endtask
  // back to idle level, then deselect; data line flips so stale bits never match
  task automatic stop();
    sck = mode3_q;
    half();
    sel_n = 1'b1;
    sdi = ~sdi;
    half();
    half();
  endtask
endmodule

//--- tb/tb.sv
// self-checking bench for the serial command front end
`timescale 1ns/1ps
module tb;
  import smcf_pkg::*;
  logic clk, rst, sel_n, sck, sdi, sdo, sdo_oe_n, cmd_valid, addr_valid, rx_valid;
  logic allowed, flag, mode3, frame_end, oe_seen;
  logic [19:0] addr;
  logic [7:0]  rx_byte, rx, st_i, tx_i;
  smcf_cmd_t   cmd;
  int          miscompares, checks, n_cmd, c0, n_addr, n_rx, a0, r0;
  logic [7:0]  ops [15] = '{8'h06, 8'h04, 8'h05, 8'h01, 8'h02, 8'h03, 8'h0B, 8'h42,
                             8'h4B, 8'h9F, 8'h4C, 8'hC2, 8'hC3, 8'hBA, 8'hB9};
  smcf_frontend #(.ADDR_W(20)) u_dut (.clk(clk), .rst(rst), .sel_n_pin(sel_n), .sck_pin(sck),
    .sdi_pin(sdi), .sdo_o(sdo), .sdo_oe_n(sdo_oe_n), .cmd_o(cmd), .cmd_valid_o(cmd_valid),
    .addr_o(addr), .addr_valid_o(addr_valid), .rx_byte_o(rx_byte), .rx_byte_valid_o(rx_valid),
    .write_allowed_o(allowed), .write_latch_flag(flag), .mode3_o(mode3),
    .frame_end_o(frame_end), .tx_byte_i(tx_i), .status_i(st_i));
  smcf_master u_m (.clk(clk), .sel_n(sel_n), .sck(sck), .sdi(sdi), .sdo(sdo), .sdo_oe_n(sdo_oe_n));
  initial clk = 1'b0;
  always #2 clk = ~clk;
  // counts decoded commands and notes any output drive
  always @(posedge clk) begin
    if (cmd_valid === 1'b1) n_cmd++;
    if (addr_valid === 1'b1) n_addr++;
    if (rx_valid === 1'b1) n_rx++;
    if (sdo_oe_n === 1'b0) oe_seen = 1'b1;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask
  // opens a frame and sends its opcode, leaving select low
  task automatic frame(input logic m3, input logic [7:0] op);
    u_m.start(m3);
    u_m.xfer(op, rx);
  endtask
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    give_verdict();
  end
  initial begin
    rst = 1'b1;
    st_i = 8'hA5;
    tx_i = 8'h3C;
    oe_seen = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk("latch_reset", 0, flag);
    chk("oe_idle", 1, sdo_oe_n);
    // every opcode, alternating clock modes; enum follows table order
    for (int i = 0; i < 15; i++) begin
      c0 = n_cmd;
      frame(i[0], ops[i]);
      chk("cmd", i + 1, cmd);
      chk("mode", i[0], mode3);
      u_m.stop();
      chk("cmd_count", c0 + 1, n_cmd);
    end
    $display("test opcodes done");
    frame(1'b0, 8'h06);
    u_m.stop();
    chk("latch_set", 1, flag);
    chk("allowed", 1, allowed);
    // a bad opcode must swallow the clear and read opcodes behind it
    oe_seen = 1'b0;
    c0 = n_cmd;
    frame(1'b0, 8'hFF);
    u_m.xfer(8'h04, rx);
    u_m.xfer(8'h05, rx);
    u_m.stop();
    chk("invalid_cmds", c0, n_cmd);
    chk("invalid_oe", 0, oe_seen);
    chk("invalid_latch", 1, flag);
    $display("test invalid done");
    frame(1'b1, 8'h05);
    u_m.xfer(8'h00, rx);
    u_m.stop();
    chk("status_rd", 8'hA7, rx);
    frame(1'b0, 8'h01);
    u_m.xfer(8'h00, rx);
    chk("latch_hold", 1, flag);
    u_m.stop();
    chk("latch_auto_clr", 0, flag);
    $display("test latch done");
    frame(1'b0, 8'h06);
    u_m.stop();
    a0 = n_addr;
    r0 = n_rx;
    frame(1'b0, 8'h02);
    u_m.xfer(8'h5B, rx);
    u_m.xfer(8'hCD, rx);
    u_m.xfer(8'hEF, rx);
    chk("addr", 20'hBCDEF, addr);
    chk("addr_strobe", a0 + 1, n_addr);
    u_m.xfer(8'h96, rx);
    chk("rx_byte", 8'h96, rx_byte);
    chk("rx_strobe", r0 + 1, n_rx);
    u_m.stop();
    chk("latch_wr_clr", 0, flag);
    $display("test write done");
    frame(1'b0, 8'h06);
    u_m.stop();
    frame(1'b0, 8'h04);
    u_m.stop();
    chk("latch_clr", 0, flag);
    frame(1'b0, 8'h05);
    u_m.xfer(8'h00, rx);
    u_m.stop();
    chk("status_clr", 8'hA5, rx);
    $display("test clear done");
    // memory read in mode 3 with the advised zero top nibble
    frame(1'b1, 8'h03);
    u_m.xfer(8'h00, rx);
    u_m.xfer(8'h01, rx);
    u_m.xfer(8'h23, rx);
    chk("rd_addr", 20'h00123, addr);
    u_m.xfer(8'h00, rx);
    u_m.stop();
    chk("rd_byte", 8'h3C, rx);
    $display("test read done");
    give_verdict();
  end
endmodule
bind smcf_frontend smcf_frontend_assertions #(.ADDR_W(ADDR_W)) u_chk (.clk(clk), .rst(rst),
  .sel_n_pin(sel_n_pin), .sck_pin(sck_pin), .sdi_pin(sdi_pin), .sdo_o(sdo_o),
  .sdo_oe_n(sdo_oe_n), .cmd_o(cmd_o), .cmd_valid_o(cmd_valid_o), .addr_o(addr_o),
  .addr_valid_o(addr_valid_o), .rx_byte_o(rx_byte_o), .rx_byte_valid_o(rx_byte_valid_o),
  .write_allowed_o(write_allowed_o), .write_latch_flag(write_latch_flag), .mode3_o(mode3_o),
  .frame_end_o(frame_end_o), .tx_byte_i(tx_byte_i), .status_i(status_i));
